// >>> shared/hb_pkg.sv
// constants of the half-bridge control and protection block
package hb_pkg;
  // system clock rate
  localparam int CLK_MHZ = 50;
  // control word layout
  localparam int WORD_W = 16;
  localparam int BIT_CLEAR = 0;
  localparam int BIT_OL_N = 13;
  localparam int BIT_DELAY_SEL = 14;
  localparam int BIT_SOFT_EN = 15;
  // switch positions in both words, index order: low a, high a, low b, high b, low c, high c
  localparam int NSW = 6;
  localparam int SW_POS [NSW] = '{3, 4, 7, 8, 11, 12};
  // status word layout
  localparam int BIT_PREWARN = 0;
  localparam int BIT_SHORT = 13;
  localparam int BIT_ENABLE = 14;
  localparam int BIT_SUPPLY = 15;
  // control word after reset: soft enable, long delay, open-load detection off
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'hE000;
  // status word during thermal shutdown
  localparam logic [WORD_W-1:0] STATUS_SHUTDOWN = 16'hFFFF;
  // serial frame length
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CNT_SAT = 5'h1F;
  // protection delays in microseconds
  localparam int SC_LONG_US = 12000;
  localparam int SC_SHORT_US = 1500;
  localparam int UV_DELAY_US = 20;
  // derived cycle counts
  localparam int SC_LONG_CYC = SC_LONG_US * CLK_MHZ;
  localparam int SC_SHORT_CYC = SC_SHORT_US * CLK_MHZ;
  localparam int UV_DELAY_CYC = UV_DELAY_US * CLK_MHZ;
  localparam int TMR_W = 20;
  // input synchroniser width and bit positions
  localparam int PIN_W = 19;
  localparam int PIN_CS_N = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DI = 2;
  localparam int PIN_EN = 3;
  localparam int PIN_TWARN = 4;
  localparam int PIN_TSHUT = 5;
  localparam int PIN_UV = 6;
  localparam int PIN_OC = 7;
  localparam int PIN_OL = 13;
endpackage

// >>> design/hb_serial.sv
// serial shifter: 16-bit frame in, status word out, abort on short frame
module hb_serial (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic di,
  input wire logic [15:0] status,
  output logic do_r,
  output logic [15:0] word_r,
  output logic word_stb_r
);
  logic cs_n_d_r;
  logic sclk_d_r;
  logic [4:0] cnt_r;
  logic [15:0] in_sh_r;
  logic [15:0] out_sh_r;
  wire cs_fall = cs_n_d_r & ~cs_n;
  wire cs_rise = ~cs_n_d_r & cs_n;
  wire sclk_rise = ~sclk_d_r & sclk & ~cs_n;
  wire frame_ok = (cnt_r == hb_pkg::FRAME_BITS);
  wire [4:0] cnt_nxt = (cnt_r == hb_pkg::CNT_SAT) ? cnt_r : cnt_r + 5'h01;

  // edge history of the filtered pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      cs_n_d_r <= cs_n;
      sclk_d_r <= sclk;
    end
  end

  // shift lsb first; bit 0 of the status word appears at chip-select fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
      in_sh_r <= 16'h0000;
      out_sh_r <= 16'h0000;
      do_r <= 1'b0;
    end else if (cs_fall) begin
      cnt_r <= 5'h00;
      out_sh_r <= status;
      do_r <= status[hb_pkg::BIT_PREWARN];
    end else if (sclk_rise) begin
      cnt_r <= cnt_nxt;
      in_sh_r <= {di, in_sh_r[15:1]};
      out_sh_r <= {1'b0, out_sh_r[15:1]};
      do_r <= out_sh_r[1];
    end
  end

  // word taken only on a complete frame; a short frame changes nothing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_r <= 16'h0000;
      word_stb_r <= 1'b0;
    end else begin
      word_stb_r <= cs_rise & frame_ok;
      if (cs_rise & frame_ok) begin
        word_r <= in_sh_r;
      end
    end
  end
endmodule

// >>> design/hb_protect.sv
// control and protection logic of a triple half-bridge driver
// Operation
// - reset word: enable, long delay, open-load off
// - run only when soft and hardware enable
// - disabled: outputs off, serial still works
// - outputs return once both enables high
// - open-load bit low enables detection, pulldowns
// - status shows open load while detection active
// - persistent overcurrent sets short flag, disables that switch
// - status clear resets short flag, re-enables
// - prewarning bit follows temperature warning input
// - prewarning bit on data out at select
// - aborted frame leaves both words unchanged
// - thermal shutdown: outputs off, status all ones
// - resume after cool down and status clear
// - persistent undervoltage sets supply fail, disables
// - supply recovery resumes; flag waits for clear
// - fault low on current limit or shutdown
// - fault held until normal operation resumes
// - short delay 12ms high, 1.5ms low
// - switch control bits at documented positions
// - status bits at documented positions
// - status clear wipes supply, short, shutdown
module hb_protect #(
  parameter int SC_LONG_CYC = hb_pkg::SC_LONG_CYC,
  parameter int SC_SHORT_CYC = hb_pkg::SC_SHORT_CYC,
  parameter int UV_DELAY_CYC = hb_pkg::UV_DELAY_CYC
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DI,
  output logic DO,
  input wire logic HW_ENABLE,
  input wire logic TEMP_WARN,
  input wire logic TEMP_SHUT,
  input wire logic SUPPLY_LOW,
  input wire logic [5:0] OVER_CURRENT,
  input wire logic [5:0] OPEN_LOAD,
  output logic [5:0] SWITCH_ON,
  output logic [2:0] PULLDOWN_ON,
  output logic FAULT_OUT,
  output logic FAULT_OE_N
);
  // cycle counts at register width
  localparam logic [hb_pkg::TMR_W-1:0] SC_LONG_LIM = hb_pkg::TMR_W'(SC_LONG_CYC);
  localparam logic [hb_pkg::TMR_W-1:0] SC_SHORT_LIM = hb_pkg::TMR_W'(SC_SHORT_CYC);
  localparam logic [hb_pkg::TMR_W-1:0] UV_LIM = hb_pkg::TMR_W'(UV_DELAY_CYC);
  localparam logic [hb_pkg::TMR_W-1:0] TMR_ONE = 20'h00001;
  localparam logic [hb_pkg::TMR_W-1:0] TMR_ZERO = 20'h00000;

  // saturating timer step toward a limit
  function automatic logic [hb_pkg::TMR_W-1:0] tmr_step(input logic [hb_pkg::TMR_W-1:0] cnt,
                                                        input logic [hb_pkg::TMR_W-1:0] lim);
    tmr_step = (cnt >= lim) ? cnt : cnt + TMR_ONE;
  endfunction

  logic [hb_pkg::PIN_W-1:0] s1_r;
  logic [hb_pkg::PIN_W-1:0] s2_r;
  logic [hb_pkg::PIN_W-1:0] s3_r;
  logic [hb_pkg::PIN_W-1:0] pin_r;
  logic [hb_pkg::PIN_W-1:0] pin_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] word;
  logic word_stb;
  logic [5:0] sw_r;
  logic [5:0] sw_nxt;
  logic [5:0] sc_off_r;
  logic [5:0] sc_hit;
  logic [5:0] req;
  logic [5:0] sw_stat;
  logic [hb_pkg::TMR_W-1:0] oc_cnt_r [hb_pkg::NSW];
  logic [hb_pkg::TMR_W-1:0] uv_cnt_r;
  logic shut_r;
  logic supply_fail_r;
  logic fault_oe_n_r;
  logic [2:0] pulldown_r;
  logic fault_out_r;

  // three-stage synchroniser on every pin; a bit changes once stages two and three agree
  // while stages two and three disagree the filtered value holds
  assign pin_nxt = (s2_r & ~(s2_r ^ s3_r)) | (pin_r & (s2_r ^ s3_r));
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s1_r <= 19'h00001;
      s2_r <= 19'h00001;
      s3_r <= 19'h00001;
      pin_r <= 19'h00001;
    end else begin
      s1_r <= {OPEN_LOAD, OVER_CURRENT, SUPPLY_LOW, TEMP_SHUT, TEMP_WARN, HW_ENABLE, DI, SCLK, CS_N};
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= pin_nxt;
    end
  end

  // filtered pin names
  wire cs_n_f = pin_r[hb_pkg::PIN_CS_N];
  wire sclk_f = pin_r[hb_pkg::PIN_SCLK];
  wire di_f = pin_r[hb_pkg::PIN_DI];
  wire en_f = pin_r[hb_pkg::PIN_EN];
  wire twarn_f = pin_r[hb_pkg::PIN_TWARN];
  wire tshut_f = pin_r[hb_pkg::PIN_TSHUT];
  wire uv_f = pin_r[hb_pkg::PIN_UV];
  wire [5:0] oc_f = pin_r[hb_pkg::PIN_OC +: hb_pkg::NSW];
  wire [5:0] ol_f = pin_r[hb_pkg::PIN_OL +: hb_pkg::NSW];

  // serial frame engine
  hb_serial u_serial (
    .clk(CLK),
    .rst_n(RST_B),
    .cs_n(cs_n_f),
    .sclk(sclk_f),
    .di(di_f),
    .status(status_r),
    .do_r(DO),
    .word_r(word),
    .word_stb_r(word_stb)
  );

  // control word, loaded only by a complete frame
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_r <= hb_pkg::CTRL_RESET;
    end else if (word_stb) begin
      ctrl_r <= word;
    end
  end

  // decoded control
  wire status_clear = word_stb & word[hb_pkg::BIT_CLEAR];
  wire soft_enable = ctrl_r[hb_pkg::BIT_SOFT_EN];
  wire short_delay_select = ctrl_r[hb_pkg::BIT_DELAY_SEL];
  wire openload_detect_n = ctrl_r[hb_pkg::BIT_OL_N];
  wire enable_eff = soft_enable & en_f;
  wire uv_off = uv_f & (uv_cnt_r >= UV_LIM);
  // the live shutdown input cuts the switches without waiting for the latch
  wire run_ok = enable_eff & ~shut_r & ~tshut_f & ~uv_off;
  wire [hb_pkg::TMR_W-1:0] sc_lim = short_delay_select ? SC_LONG_LIM : SC_SHORT_LIM;
  wire short_flag = |sc_off_r;
  wire ol_mode = ~openload_detect_n;

  // per-switch requests, interlocked, gated by enables and protection
  always_comb begin
    req = 6'h00;
    sw_stat = 6'h00;
    sc_hit = 6'h00;
    for (int i = 0; i < hb_pkg::NSW; i++) begin
      req[i] = ctrl_r[hb_pkg::SW_POS[i]];
      sw_stat[i] = (ol_mode & ~sw_r[i]) ? ol_f[i] : sw_r[i];
      sc_hit[i] = oc_f[i] & sw_r[i] & (oc_cnt_r[i] >= sc_lim);
    end
    for (int c = 0; c < 3; c++) begin
      if (req[2*c] & req[2*c+1]) begin
        req[2*c] = 1'b0;
        req[2*c+1] = 1'b0;
      end
    end
  end
  assign sw_nxt = req & ~sc_off_r & ~sc_hit & {6{run_ok}};

  // status word, all ones while thermal shutdown is latched
  always_comb begin
    status_nxt = 16'h0000;
    status_nxt[hb_pkg::BIT_PREWARN] = twarn_f;
    for (int i = 0; i < hb_pkg::NSW; i++) begin
      status_nxt[hb_pkg::SW_POS[i]] = sw_stat[i];
    end
    status_nxt[hb_pkg::BIT_SHORT] = short_flag;
    status_nxt[hb_pkg::BIT_ENABLE] = enable_eff;
    status_nxt[hb_pkg::BIT_SUPPLY] = supply_fail_r;
    if (shut_r) begin
      status_nxt = hb_pkg::STATUS_SHUTDOWN;
    end
  end

  // overcurrent timers, one per switch, counted in system cycles
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < hb_pkg::NSW; i++) begin
        oc_cnt_r[i] <= TMR_ZERO;
      end
    end else begin
      for (int i = 0; i < hb_pkg::NSW; i++) begin
        oc_cnt_r[i] <= (oc_f[i] & sw_r[i]) ? tmr_step(oc_cnt_r[i], sc_lim) : TMR_ZERO;
      end
    end
  end

  // short latch per switch; a new trip wins over a clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sc_off_r <= 6'h00;
    end else begin
      sc_off_r <= (sc_off_r & ~{6{status_clear}}) | sc_hit;
    end
  end

  // undervoltage timer
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      uv_cnt_r <= TMR_ZERO;
    end else begin
      uv_cnt_r <= uv_f ? tmr_step(uv_cnt_r, UV_LIM) : TMR_ZERO;
    end
  end

  // sticky supply-fail and thermal shutdown flags; set wins over clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      supply_fail_r <= 1'b0;
      shut_r <= 1'b0;
    end else begin
      supply_fail_r <= (supply_fail_r & ~status_clear) | uv_off;
      shut_r <= (shut_r & ~status_clear) | tshut_f;
    end
  end

  // registered outputs and status
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sw_r <= 6'h00;
      status_r <= 16'h0000;
      pulldown_r <= 3'h0;
      fault_oe_n_r <= 1'b1;
      fault_out_r <= 1'b0;
    end else begin
      sw_r <= sw_nxt;
      status_r <= status_nxt;
      pulldown_r <= {3{ol_mode}};
      fault_oe_n_r <= ~((|(oc_f & sw_r)) | short_flag | shut_r | tshut_f);
      fault_out_r <= 1'b0;
    end
  end

  // pin drivers
  assign SWITCH_ON = sw_r;
  assign PULLDOWN_ON = pulldown_r;
  assign FAULT_OUT = fault_out_r;
  assign FAULT_OE_N = fault_oe_n_r;
endmodule

// >>> tb/hb_props.sv
// assertion checker for the half-bridge control block
module hb_props #(
  parameter int SC_LONG_CYC = 40,
  parameter int UV_DELAY_CYC = 10
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CS_N,
  input wire logic DO,
  input wire logic HW_ENABLE,
  input wire logic TEMP_WARN,
  input wire logic TEMP_SHUT,
  input wire logic SUPPLY_LOW,
  input wire logic [5:0] OVER_CURRENT,
  input wire logic [5:0] SWITCH_ON,
  input wire logic FAULT_OUT,
  input wire logic FAULT_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  int uv_cnt_r;
  int oc_cnt_r;
  // run lengths of undervoltage and of overcurrent on a live switch
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      uv_cnt_r <= 0;
      oc_cnt_r <= 0;
    end else begin
      uv_cnt_r <= SUPPLY_LOW ? uv_cnt_r + 1 : 0;
      oc_cnt_r <= |(OVER_CURRENT & SWITCH_ON) ? oc_cnt_r + 1 : 0;
    end
  end
  // select falls while hot
  sequence hot_select;
    (TEMP_WARN || TEMP_SHUT)[*8] ##0 $fell(CS_N);
  endsequence
  a_pair_exclusive: assert property (!(SWITCH_ON[0] && SWITCH_ON[1]) && !(SWITCH_ON[2] && SWITCH_ON[3])
    && !(SWITCH_ON[4] && SWITCH_ON[5])) else $error("both switches of a channel on");
  a_standby_off: assert property ((!HW_ENABLE)[*6] |-> SWITCH_ON == 6'h00)
    else $error("switch on in standby");
  a_shutdown_off: assert property (TEMP_SHUT[*6] |-> SWITCH_ON == 6'h00 && !FAULT_OE_N)
    else $error("shutdown not applied");
  a_fault_data: assert property (FAULT_OUT == 1'b0) else $error("fault data high");
  a_current_fault: assert property ((|(OVER_CURRENT & SWITCH_ON))[*6] |-> !FAULT_OE_N)
    else $error("fault not raised");
  a_short_bound: assert property (oc_cnt_r <= SC_LONG_CYC + 8) else $error("overcurrent not cut");
  a_supply_off: assert property (uv_cnt_r > UV_DELAY_CYC + 6 |-> SWITCH_ON == 6'h00)
    else $error("undervoltage not cut");
  a_hot_read: assert property (hot_select |-> ##[3:8] DO) else $error("hot bit not shown");
endmodule
bind hb_protect hb_props #(.SC_LONG_CYC(SC_LONG_CYC), .UV_DELAY_CYC(UV_DELAY_CYC)) hb_props_inst (
  .CLK(CLK), .RST_B(RST_B), .CS_N(CS_N), .DO(DO), .HW_ENABLE(HW_ENABLE), .TEMP_WARN(TEMP_WARN),
  .TEMP_SHUT(TEMP_SHUT), .SUPPLY_LOW(SUPPLY_LOW), .OVER_CURRENT(OVER_CURRENT), .SWITCH_ON(SWITCH_ON),
  .FAULT_OUT(FAULT_OUT), .FAULT_OE_N(FAULT_OE_N));

// >>> tb/hb_host.sv
// host model: serial master writing the control word and reading status
module hb_host (
  input wire logic CLK,
  input wire logic DO,
  output logic CS_N,
  output logic SCLK,
  output logic DI
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels
  initial begin
    CS_N = 1'b1;
    SCLK = 1'b0;
    DI = 1'b0;
  end
  // wait whole cycles, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // frame of n clocks, lsb first; other than 16 is an abort
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] st);
    st = 16'h0000;
    CS_N = 1'b0;
    DI = w[0];
    tick(8);
    st[0] = DO;
    for (int i = 0; i < n; i++) begin
      SCLK = 1'b1;
      tick(4);
      SCLK = 1'b0;
      tick(4);
      if (i < 15) st[i + 1] = DO;
      DI = w[(i + 1) % 16];
    end
    CS_N = 1'b1;
    DI = ~DI;
    tick(12);
  endtask
endmodule

// >>> tb/hb_protect_test.sv
// self-checking bench of the half-bridge control block
module hb_protect_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SHORT_C = 20;
  localparam int UV_C = 10;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic HW_ENABLE, TEMP_WARN, TEMP_SHUT, SUPPLY_LOW, DO, CS_N, SCLK, DI, FAULT_OUT, FAULT_OE_N;
  logic [5:0] OVER_CURRENT, OPEN_LOAD, SWITCH_ON;
  logic [2:0] PULLDOWN_ON;
  logic [15:0] st;
  logic [15:0] word;
  logic [31:0] seed = 32'h58270D65;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  hb_protect #(.SC_LONG_CYC(40), .SC_SHORT_CYC(SHORT_C), .UV_DELAY_CYC(UV_C)) hb_protect_inst (
    .CLK(CLK), .RST_B(RST_B), .CS_N(CS_N), .SCLK(SCLK), .DI(DI), .DO(DO), .HW_ENABLE(HW_ENABLE),
    .TEMP_WARN(TEMP_WARN), .TEMP_SHUT(TEMP_SHUT), .SUPPLY_LOW(SUPPLY_LOW), .OVER_CURRENT(OVER_CURRENT),
    .OPEN_LOAD(OPEN_LOAD), .SWITCH_ON(SWITCH_ON), .PULLDOWN_ON(PULLDOWN_ON), .FAULT_OUT(FAULT_OUT),
    .FAULT_OE_N(FAULT_OE_N));
  hb_host hb_host_inst (.CLK(CLK), .DO(DO), .CS_N(CS_N), .SCLK(SCLK), .DI(DI));
  // clock and hang guard
  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  function automatic void next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction
  // model: requested switches, pairs cancel, gated by enable
  function automatic logic [5:0] want_sw(input logic [15:0] w, input logic en);
    logic [5:0] r;
    for (int i = 0; i < 6; i++) r[i] = w[hb_pkg::SW_POS[i]] & ~w[hb_pkg::SW_POS[i ^ 1]] & en;
    return r;
  endfunction
  // model: status word; fl[0] short, fl[1] supply fail
  function automatic logic [15:0] want_st(input logic [15:0] w, input logic [5:0] sw, input logic [1:0] fl);
    logic [15:0] s;
    s = {fl[1], w[15] & HW_ENABLE, fl[0], 12'h000, TEMP_WARN};
    for (int i = 0; i < 6; i++) s[hb_pkg::SW_POS[i]] = sw[i] | (~w[13] & OPEN_LOAD[i]);
    return s;
  endfunction
  // write a word, then rewrite it without clear and compare
  task automatic apply(input logic [15:0] w, input logic [5:0] sw, input logic [1:0] fl);
    hb_host_inst.xfer(w, 16, st);
    hb_host_inst.xfer(w & 16'hFFFE, 16, st);
    check({10'h000, SWITCH_ON}, {10'h000, sw});
    check({13'h0, PULLDOWN_ON}, {13'h0, {3{~w[13]}}});
    check(st, want_st(w, sw, fl));
  endtask
  // main sequence
  initial begin
    {HW_ENABLE, TEMP_WARN, TEMP_SHUT, SUPPLY_LOW} = 4'h8;
    OVER_CURRENT = 6'h00;
    OPEN_LOAD = 6'h00;
    repeat (3) @(posedge CLK);
    #1 RST_B = 1'b1;
    hb_host_inst.tick(6);
    hb_host_inst.xfer(16'h0000, 17, st);
    check(st, 16'h4000);
    for (int n = 0; n < 40; n++) begin
      next_rand();
      word = seed[15:0] & 16'hFFFE;
      {HW_ENABLE, TEMP_WARN} = seed[17:16];
      OPEN_LOAD = seed[23:18];
      apply(word, want_sw(word, word[15] & HW_ENABLE), 2'b00);
    end
    HW_ENABLE = 1'b1;
    apply(16'hE008, 6'h01, 2'b00);
    hb_host_inst.xfer(16'hE010, 0, st);
    check({15'h0000, st[0]}, {15'h0000, TEMP_WARN});
    check({10'h000, SWITCH_ON}, 16'h0001);
    apply(16'hA010, 6'h02, 2'b00);
    OVER_CURRENT = 6'h02;
    hb_host_inst.tick(8);
    check({15'h0000, FAULT_OE_N}, 16'h0000);
    hb_host_inst.tick(SHORT_C + 6);
    check({10'h000, SWITCH_ON}, 16'h0000);
    OVER_CURRENT = 6'h00;
    apply(16'hA010, 6'h00, 2'b01);
    apply(16'hA011, 6'h02, 2'b00);
    OPEN_LOAD = 6'h08;
    apply(16'h8010, 6'h02, 2'b00);
    OPEN_LOAD = 6'h00;
    TEMP_SHUT = 1'b1;
    hb_host_inst.tick(8);
    hb_host_inst.xfer(16'hA010, 16, st);
    check(st, hb_pkg::STATUS_SHUTDOWN);
    TEMP_SHUT = 1'b0;
    hb_host_inst.xfer(16'hA010, 16, st);
    check({10'h000, SWITCH_ON}, 16'h0000);
    apply(16'hA011, 6'h02, 2'b00);
    check({15'h0000, FAULT_OE_N}, 16'h0001);
    SUPPLY_LOW = 1'b1;
    hb_host_inst.tick(UV_C + 8);
    check({10'h000, SWITCH_ON}, 16'h0000);
    SUPPLY_LOW = 1'b0;
    apply(16'hA010, 6'h02, 2'b10);
    apply(16'hA011, 6'h02, 2'b00);
    print_verdict();
  end
endmodule
